/* File: rtl/sarc_cfg.svh */
/*
 Constants of the converter controller: register addresses, field positions,
 reset values and conversion timing counts.
 Assumes inclusion by bare name from the controller package and module.
*/
`ifndef SARC_CFG_SVH
`define SARC_CFG_SVH

// Register addresses on the internal bus
`define SARC_ADDR_MODE      16'hff28
`define SARC_ADDR_CHAN      16'hff29
`define SARC_ADDR_PINCFG    16'hff2f
`define SARC_ADDR_RES_LO    16'hff08
`define SARC_ADDR_RES_HI    16'hff09
`define SARC_ADDR_RES_BYTE  16'hff1f

// Mode, channel, pin and result register field positions
`define SARC_MODE_RUN_BIT   7
`define SARC_MODE_FIX_BIT   6
`define SARC_MODE_RATE_MSB  5
`define SARC_MODE_RATE_LSB  3
`define SARC_MODE_LV_MSB    2
`define SARC_MODE_LV_LSB    1
`define SARC_MODE_COMP_BIT  0
`define SARC_CHAN_MSB       2
`define SARC_PINCFG_MSB     3
`define SARC_RES_FILL       6

// Reset values
`define SARC_MODE_RST       8'h00
`define SARC_CHAN_RST       3'h0
`define SARC_PINCFG_RST     4'h0
`define SARC_RES_RST        10'h000

// Comparator settling time and its cycle count at the clock rate
`define SARC_CLK_MHZ        20
`define SARC_SETTLE_NS      1000
`define SARC_SETTLE_CYC     5'((`SARC_SETTLE_NS * `SARC_CLK_MHZ + 999) / 1000)

// Conversion clock dividers per rate code
`define SARC_DIV_0          4'd12
`define SARC_DIV_1          4'd8
`define SARC_DIV_2          4'd6
`define SARC_DIV_3          4'd4
`define SARC_DIV_4          4'd3
`define SARC_DIV_5          4'd2

// Whole conversion lengths in clocks, normal and low-voltage field
`define SARC_TOT0_0         9'd264
`define SARC_TOT0_1         9'd176
`define SARC_TOT0_2         9'd132
`define SARC_TOT0_3         9'd88
`define SARC_TOT0_4         9'd66
`define SARC_TOT0_5         9'd44
`define SARC_TOT1_0         9'd480
`define SARC_TOT1_1         9'd320
`define SARC_TOT1_2         9'd240
`define SARC_TOT1_3         9'd160
`define SARC_TOT1_4         9'd120
`define SARC_TOT1_5         9'd80
`define SARC_BITS           4'd10

`endif

/* File: rtl/sarc_pkg.sv */
/*
 Types of the converter controller: bus request, mode layout, timing, states.
 Assumes the constants header is on the include path.
*/
`include "sarc_cfg.svh"

package sarc_pkg;

	// Controller states
	typedef enum logic [1:0] {SARC_IDLE, SARC_SAMPLE, SARC_CONVERT} sarc_state_type;

	// Internal bus request
	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} sarc_bus_req_type;

	// Mode register layout, most significant field first
	typedef struct packed {
		logic       run;
		logic       fixed_zero;
		logic [2:0] rate;
		logic [1:0] lv;
		logic       comp;
	} sarc_mode_type;

	// Decoded conversion timing
	typedef struct packed {
		logic       valid;
		logic [3:0] div;
		logic [8:0] sample_cyc;
		logic [8:0] total;
	} sarc_timing_type;

endpackage

/* File: rtl/sarc_ctrl.sv */
/*
 Successive-approximation converter controller: mode, channel and pin
 registers, repeated conversion sequencing, result registers, done pulse.
 Assumes a held bus request that is taken when o_wait is low, and an analog
 front end that tracks while o_track is high, holds while o_hold is high and
 answers each trial code on i_comp_hi within the same conversion clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "sarc_cfg.svh"

module sarc_ctrl
(
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	input  wire sarc_pkg::sarc_bus_req_type i_bus,
	output var  logic [7:0]                o_rdata,
	output logic                           o_wait,
	input  wire logic                      i_comp_hi,
	output var  logic                      o_comp_en,
	output var  logic                      o_track,
	output var  logic                      o_hold,
	output var  logic [2:0]                o_channel,
	output var  logic [9:0]                o_trial,
	output var  logic [7:0]                o_pin_digital,
	output var  logic                      o_conv_done_irq
);
	import sarc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decoders

	// Timing of a rate and low-voltage code
	function automatic sarc_timing_type timing_of(input logic [2:0] rate, input logic [1:0] lv);
		sarc_timing_type t;
		t = '0;
		t.valid = 1'b1;
		case (rate)
			3'h0: t.div = `SARC_DIV_0;
			3'h1: t.div = `SARC_DIV_1;
			3'h2: t.div = `SARC_DIV_2;
			3'h3: t.div = `SARC_DIV_3;
			3'h4: t.div = `SARC_DIV_4;
			3'h5: t.div = `SARC_DIV_5;
			default: t.valid = 1'b0;
		endcase
		case ({lv, rate})
			5'h00: t.total = `SARC_TOT0_0;
			5'h01: t.total = `SARC_TOT0_1;
			5'h02: t.total = `SARC_TOT0_2;
			5'h03: t.total = `SARC_TOT0_3;
			5'h04: t.total = `SARC_TOT0_4;
			5'h05: t.total = `SARC_TOT0_5;
			5'h08: t.total = `SARC_TOT1_0;
			5'h09: t.total = `SARC_TOT1_1;
			5'h0a: t.total = `SARC_TOT1_2;
			5'h0b: t.total = `SARC_TOT1_3;
			5'h0c: t.total = `SARC_TOT1_4;
			5'h0d: t.total = `SARC_TOT1_5;
			default: t.valid = 1'b0;
		endcase
		t.sample_cyc = t.total - 9'({5'h00, t.div} * {5'h00, `SARC_BITS});
		return t;
	endfunction

	// Accesses that cost a wait cycle: result reads and mode, channel and pin writes
	function automatic logic waited(input sarc_bus_req_type b);
		return (b.rd && (b.addr == `SARC_ADDR_RES_LO || b.addr == `SARC_ADDR_RES_HI
			|| b.addr == `SARC_ADDR_RES_BYTE))
			|| (b.wr && (b.addr == `SARC_ADDR_MODE || b.addr == `SARC_ADDR_CHAN
			|| b.addr == `SARC_ADDR_PINCFG));
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers and state

	sarc_mode_type   mode_r;
	logic [2:0]      chan_r;
	logic [3:0]      pincfg_r;
	logic [9:0]      result_r;
	logic            wait_seen_r;
	sarc_state_type  state_r;
	logic [8:0]      cnt_r;
	logic [3:0]      bit_r;
	logic [3:0]      div_r;
	logic [9:0]      sar_r;
	logic [9:0]      sar_nxt;
	logic [4:0]      settle_r;
	logic            discard_r;
	logic            taken;
	logic            done;
	logic            start;
	logic            step_end;
	sarc_timing_type tim;

	// Bus handshake: first cycle of a waited access stalls
	assign o_wait = waited(i_bus) && !wait_seen_r;
	assign taken = (i_bus.rd || i_bus.wr) && !o_wait;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			wait_seen_r <= 1'b0;
		else
			wait_seen_r <= waited(i_bus) && !wait_seen_r;
	end

	// Register writes
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			mode_r   <= `SARC_MODE_RST;
			chan_r   <= `SARC_CHAN_RST;
			pincfg_r <= `SARC_PINCFG_RST;
		end
		else if (taken && i_bus.wr)
		begin
			if (i_bus.addr == `SARC_ADDR_MODE)
			begin
				mode_r.run        <= i_bus.wdata[`SARC_MODE_RUN_BIT];
				mode_r.fixed_zero <= 1'b0;
				mode_r.rate       <= i_bus.wdata[`SARC_MODE_RATE_MSB:`SARC_MODE_RATE_LSB];
				mode_r.lv         <= i_bus.wdata[`SARC_MODE_LV_MSB:`SARC_MODE_LV_LSB];
				mode_r.comp       <= i_bus.wdata[`SARC_MODE_COMP_BIT];
			end
			if (i_bus.addr == `SARC_ADDR_CHAN)
				chan_r <= i_bus.wdata[`SARC_CHAN_MSB:0];
			if (i_bus.addr == `SARC_ADDR_PINCFG)
				pincfg_r <= i_bus.wdata[`SARC_PINCFG_MSB:0];
		end
	end

	// Register reads, answered one cycle after the request is taken
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_rdata <= 8'h00;
		else if (taken && i_bus.rd)
		begin
			case (i_bus.addr)
				`SARC_ADDR_MODE:     o_rdata <= mode_r;
				`SARC_ADDR_CHAN:     o_rdata <= {5'h00, chan_r};
				`SARC_ADDR_PINCFG:   o_rdata <= {4'h0, pincfg_r};
				`SARC_ADDR_RES_LO:   o_rdata <= {result_r[1:0], `SARC_RES_FILL'(0)};
				`SARC_ADDR_RES_HI:   o_rdata <= result_r[9:2];
				`SARC_ADDR_RES_BYTE: o_rdata <= result_r[9:2];
				default:             o_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparator power and settling

	// Comparator powered while the mode comp bit is set, one clock later
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_comp_en <= 1'b0;
		else
			o_comp_en <= mode_r.comp;
	end

	// Cycles since comparator enable, saturating at the settle count
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !mode_r.comp)
			settle_r <= 5'h00;
		else if (settle_r != `SARC_SETTLE_CYC)
			settle_r <= settle_r + 5'h01;
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencer

	assign tim = timing_of(mode_r.rate, mode_r.lv);
	assign step_end = (cnt_r == 9'h000);
	assign done = (state_r == SARC_CONVERT) && step_end && (bit_r == 4'h0) && mode_r.run;
	assign start = mode_r.run && tim.valid && ((state_r == SARC_IDLE) || done);

	// Current bit decided, next lower bit set on trial
	always_comb
	begin
		sar_nxt = sar_r;
		sar_nxt[bit_r] = i_comp_hi;
		if (bit_r != 4'h0)
			sar_nxt[bit_r - 4'h1] = 1'b1;
	end

	// State, step counter and approximation register
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !mode_r.run)
		begin
			state_r <= SARC_IDLE;
			cnt_r   <= 9'h000;
			bit_r   <= 4'h0;
			div_r   <= 4'h0;
			sar_r   <= 10'h000;
		end
		else if (start)
		begin
			state_r <= SARC_SAMPLE;
			cnt_r   <= tim.sample_cyc - 9'h001;
			div_r   <= tim.div;
			bit_r   <= `SARC_BITS - 4'h1;
			sar_r   <= 10'h000;
		end
		else
		begin
			unique case (state_r)
				SARC_IDLE: state_r <= SARC_IDLE;
				SARC_SAMPLE:
				begin
					cnt_r <= cnt_r - 9'h001;
					if (step_end)
					begin
						state_r <= SARC_CONVERT;
						cnt_r   <= {5'h00, div_r} - 9'h001;
						sar_r   <= 10'h200;
					end
				end
				SARC_CONVERT:
				begin
					cnt_r <= cnt_r - 9'h001;
					if (step_end)
					begin
						sar_r <= sar_nxt;
						bit_r <= bit_r - 4'h1;
						cnt_r <= {5'h00, div_r} - 9'h001;
					end
				end
			endcase
		end
	end

	// First result after a fresh start is dropped if the comparator was unsettled
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			discard_r <= 1'b0;
		else if (start && state_r == SARC_IDLE)
			discard_r <= !(mode_r.comp && settle_r == `SARC_SETTLE_CYC);
		else if (done)
			discard_r <= 1'b0;
	end

	// Result store and done pulse
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			result_r        <= `SARC_RES_RST;
			o_conv_done_irq <= 1'b0;
		end
		else
		begin
			o_conv_done_irq <= done && !discard_r;
			if (done && !discard_r)
				result_r <= sar_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Front end drive

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_track   <= 1'b0;
			o_hold    <= 1'b0;
			o_channel <= 3'h0;
			o_trial   <= 10'h000;
		end
		else
		begin
			o_track <= (state_r == SARC_SAMPLE);
			o_hold  <= (state_r == SARC_CONVERT);
			o_trial <= sar_r;
			if (start)
				o_channel <= chan_r;
		end
	end

	// Pin function: the lowest n pins are digital
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_pin
			always_ff @(posedge i_clk)
			begin
				if (i_srst)
					o_pin_digital[gi] <= 1'b0;
				else
					o_pin_digital[gi] <= (pincfg_r > 4'(gi));
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Checks

	logic [8:0] elapsed_r;
	always_ff @(posedge i_clk)
	begin
		if (i_srst || start)
			elapsed_r <= 9'h000;
		else
			elapsed_r <= elapsed_r + 9'h001;
	end

	sequence s_waited_req;
		waited(i_bus) && !wait_seen_r;
	endsequence

	a_done_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
		done && !discard_r |=> o_conv_done_irq ##1 !o_conv_done_irq)
		else $error("done pulse missing");
	a_result_copy: assert property (@(posedge i_clk) disable iff (i_srst)
		done && !discard_r |=> result_r == $past(sar_nxt))
		else $error("result not copied");
	a_low_zero: assert property (@(posedge i_clk) disable iff (i_srst)
		taken && i_bus.rd && i_bus.addr == `SARC_ADDR_RES_LO |=> o_rdata[5:0] == 6'h00)
		else $error("low result bits not zero");
	a_byte_upper: assert property (@(posedge i_clk) disable iff (i_srst)
		taken && i_bus.rd && i_bus.addr == `SARC_ADDR_RES_BYTE
		|=> o_rdata == $past(result_r[9:2]))
		else $error("byte result wrong");
	a_access_wait: assert property (@(posedge i_clk) disable iff (i_srst)
		s_waited_req ##1 $stable(i_bus) |-> !o_wait && taken)
		else $error("wait cycle wrong");
	a_hold_chan: assert property (@(posedge i_clk) disable iff (i_srst)
		state_r == SARC_CONVERT && $past(state_r) == SARC_CONVERT |-> $stable(o_channel))
		else $error("channel moved during hold");
	a_mode_reset: assert property (@(posedge i_clk)
		i_srst |=> mode_r == `SARC_MODE_RST && !o_conv_done_irq)
		else $error("mode not reset");
	a_conv_len: assert property (@(posedge i_clk) disable iff (i_srst)
		done |-> elapsed_r + 9'h001 == $past(tim.total, 1) || $changed(tim.total))
		else $error("conversion length wrong");
	a_settle_drop: assert property (@(posedge i_clk) disable iff (i_srst)
		start && state_r == SARC_IDLE && settle_r < `SARC_SETTLE_CYC |=> discard_r)
		else $error("unsettled start not discarded");
	a_abort_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
		!mode_r.run && !$past(mode_r.run) |-> state_r == SARC_IDLE && !o_conv_done_irq)
		else $error("abort not clean");

endmodule

`default_nettype wire

/* File: tb/sarc_afe_model.sv */
/*
 Behavioural analog front end: per-channel levels, sample-hold, comparator.
 Assumes track, hold, channel and trial code driven by the controller.
*/
`timescale 1ns/1ns
`default_nettype none

module sarc_afe_model
#(
	parameter logic [79:0] LEVELS = 80'h0
)
(
	input  wire logic       i_clk,
	input  wire logic       i_track,
	input  wire logic       i_hold,
	input  wire logic [2:0] i_channel,
	input  wire logic [9:0] i_trial,
	output var  logic       o_comp_hi
);
	logic [9:0] held_r;
	logic       idle_r = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Follow the selected input while tracking, freeze it while holding
	always @(posedge i_clk)
	begin
		if (i_track)
			held_r <= LEVELS[i_channel*10 +: 10];
		idle_r <= ~idle_r;
	end

	// Outside the hold phase the answer toggles, so it cannot be relied on
	assign o_comp_hi = i_hold ? (held_r >= i_trial) : idle_r;
endmodule

`default_nettype wire

/* File: tb/sarc_ctrl_tb.sv */
/*
 Self-checking bench of the converter controller.
 Assumes the package, the controller and the front-end model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module sarc_ctrl_tb;
	import sarc_pkg::*;
	localparam logic [9:0] V3 = 10'h2b5;
	localparam logic [9:0] V5 = 10'h14a;
	logic             clk;
	logic             srst;
	sarc_bus_req_type bus_req;
	logic [7:0]       rdata;
	logic             wt;
	logic             comp_hi;
	logic             comp_en;
	logic             track;
	logic             hold;
	logic [2:0]       chan;
	logic [9:0]       trial;
	logic [7:0]       pins;
	logic             irq;
	int               n_errors = 0;
	int               checks_done = 0;
	int               cyc = 0;
	int               irq_cnt = 0;
	int               last_irq = 0;
	int               prev_irq = 0;

	sarc_ctrl i_dut (.i_clk(clk), .i_srst(srst), .i_bus(bus_req), .o_rdata(rdata),
		.o_wait(wt), .i_comp_hi(comp_hi), .o_comp_en(comp_en), .o_track(track),
		.o_hold(hold), .o_channel(chan), .o_trial(trial), .o_pin_digital(pins),
		.o_conv_done_irq(irq));

	sarc_afe_model #(.LEVELS({20'h0, V5, 10'h0, V3, 30'h0})) i_afe (.i_clk(clk),
		.i_track(track), .i_hold(hold), .i_channel(chan), .i_trial(trial),
		.o_comp_hi(comp_hi));

	////////////////////////////////////////////////////////////////////////////
	// Clock and done-pulse monitor
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
		begin
			irq_cnt <= irq_cnt + 1;
			prev_irq <= last_irq;
			last_irq <= cyc;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks
	task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_int(input int got, input int exp, input string what);
		checks_done++;
		if (got != exp)
		begin
			n_errors++;
			$display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	// Holds the request until taken, counts wait cycles, returns read data
	task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d,
		output logic [7:0] q, output int nw);
		nw = 0;
		bus_req <= '{addr: a, wr: w, rd: !w, wdata: d};
		#1;
		while (wt === 1'b1)
		begin
			@(posedge clk);
			#1;
			nw++;
		end
		@(posedge clk);
		#1;
		q = rdata;
		bus_req <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
		@(posedge clk);
		#1;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e, input int ew);
		logic [7:0] q;
		int         nw;
		access(a, 1'b0, 8'h00, q, nw);
		check8(q, e, "read data");
		check_int(nw, ew, "read wait");
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input int ew);
		logic [7:0] q;
		int         nw;
		access(a, 1'b1, d, q, nw);
		check_int(nw, ew, "write wait");
	endtask

	task automatic wait_irq(input int n, input int lim);
		int k;
		k = 0;
		while (irq_cnt < n && k < lim)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		check_int(int'(irq_cnt >= n), 1, "done pulse missing");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rd(16'hff28, 8'h00, 0);
		rd(16'hff09, 8'h00, 1);
		rd(16'hff08, 8'h00, 1);
		rd(16'hff1f, 8'h00, 1);
		rd(16'hff29, 8'h00, 0);
		rd(16'hff00, 8'h00, 0);
		check8({7'h0, comp_en}, 8'h00, "comparator power");
		$display("test reset done");
	endtask

	task automatic t_pins();
		for (int n = 0; n < 10; n++)
		begin
			wr(16'hff2f, 8'(n), 1);
			check8(pins, (n >= 8) ? 8'hff : 8'((1 << n) - 1), "digital pins");
		end
		wr(16'hff28, 8'h40, 1);
		rd(16'hff28, 8'h00, 0);
		$display("test pins done");
	endtask

	task automatic t_rates();
		int tot [2][6] = '{'{264, 176, 132, 88, 66, 44}, '{480, 320, 240, 160, 120, 80}};
		int base;
		wr(16'hff29, 8'h03, 1);
		wr(16'hff28, 8'h01, 1);
		repeat (25) @(posedge clk);
		#1;
		check8({7'h0, comp_en}, 8'h01, "comparator power");
		for (int lv = 0; lv < 2; lv++)
			for (int r = 0; r < 6; r++)
			begin
				wr(16'hff28, {2'b00, 3'(r), 2'(lv), 1'b1}, 1);
				base = irq_cnt;
				wr(16'hff28, {2'b10, 3'(r), 2'(lv), 1'b1}, 1);
				wait_irq(base + 2, 1100);
				check_int(last_irq - prev_irq, tot[lv][r], "conversion length");
			end
		check8({5'h0, chan}, 8'h03, "channel");
		rd(16'hff09, V3[9:2], 1);
		rd(16'hff08, {V3[1:0], 6'h00}, 1);
		rd(16'hff1f, V3[9:2], 1);
		$display("test rates done");
	endtask

	task automatic t_abort();
		int base;
		wr(16'hff28, 8'h01, 1);
		wr(16'hff29, 8'h05, 1);
		wr(16'hff28, 8'ha9, 1);
		repeat (20) @(posedge clk);
		#1;
		base = irq_cnt;
		wr(16'hff28, 8'h01, 1);
		wr(16'hff28, 8'h85, 1);
		repeat (600) @(posedge clk);
		#1;
		check_int(irq_cnt, base, "pulse after abort");
		rd(16'hff09, V3[9:2], 1);
		$display("test abort done");
	endtask

	task automatic t_discard();
		int base;
		int t0;
		wr(16'hff28, 8'h00, 1);
		repeat (5) @(posedge clk);
		#1;
		base = irq_cnt;
		t0 = cyc;
		wr(16'hff28, 8'ha8, 1);
		check8({7'h0, comp_en}, 8'h00, "comparator power");
		wait_irq(base + 1, 300);
		check_int(int'(last_irq - t0 > 60), 1, "first result kept");
		rd(16'hff09, V5[9:2], 1);
		rd(16'hff08, {V5[1:0], 6'h00}, 1);
		wr(16'hff28, 8'h00, 1);
		$display("test discard done");
	endtask

	// Reset in the middle of a conversion clears every register
	task automatic t_midreset();
		wr(16'hff28, 8'ha9, 1);
		repeat (30) @(posedge clk);
		#1;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		srst = 1'b0;
		rd(16'hff28, 8'h00, 0);
		rd(16'hff09, 8'h00, 1);
		rd(16'hff29, 8'h00, 0);
		check8(pins, 8'h00, "digital pins");
		check8({7'h0, comp_en}, 8'h00, "comparator power");
		$display("test mid reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Verdict, main sequence and watchdog
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		srst = 1'b1;
		bus_req = '0;
		repeat (3) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_pins();
		t_rates();
		t_abort();
		t_discard();
		t_midreset();
		print_verdict();
	end

	initial
	begin
		#1_000_000;
		n_errors++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
endmodule

`default_nettype wire
